/* bldc_predriver_control.sv */
// Commutation, chopping, protection and lock detect of a BLDC pre-driver
//
// Function
// - Sense trip stops source, starts off-time
// - Off-time lasts 25 us
// - Chop low drives selected pair
// - Chop high switches source off
// - Chop high over 3 ms disables gates
// - Blank sense 1.5 us after off-time
// - Chop-on or direction change restarts blanking
// - Synchronous rectification in off periods when enabled and no overvoltage
// - Brake: all low sides on
// - Brake beats chop and lock shutdown
// - Chop high over 3 ms: standby, bias off
// - Pump fault disables gates
// - Undervoltage, overtemperature, reset disable gates
// - Overvoltage suppresses synchronous rectification
// - Overtemperature disables outputs until cleared
// - First tach toggles on any Hall edge
// - Second tach toggles on phase A edge
// - Lock: no good Hall step
// - Lock for 127 oscillator cycles latches fault
// - Lock clears by direction, reset, long chop
// - Brake halts lock; grounded capacitor disables
// - Hall table selects gates; invalid states off
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "bldc_defs.svh"
module bldc_predriver_control
  import bldc_pkg::*;
#(
  parameter int STBY_CYCLES = `STBY_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Hall sensors and controller
  input wire logic phase_a_hall_input,
  input wire logic phase_b_hall_input,
  input wire logic phase_c_hall_input,
  input wire logic direction,
  input wire logic chop_input_low_active,
  input wire logic brake_request_low,
  // Analog monitors
  input wire logic trip_current_reached,
  input wire logic pump_voltage_fault,
  input wire logic motor_supply_undervoltage,
  input wire logic supply_overvoltage_level_exceeded,
  input wire logic overtemperature,
  input wire logic lock_timer_capacitor_osc,
  input wire logic lock_timer_capacitor_grounded,
  // Gate drivers and Hall bias
  output var gate_type gate_drive,
  output logic hall_bias_supply,
  // Open-drain tachometer pins
  input wire logic hall_edge_toggle_in,
  output logic hall_edge_toggle_out,
  output logic hall_edge_toggle_oe,
  input wire logic phase_a_toggle_in,
  output logic phase_a_toggle_out,
  output logic phase_a_toggle_oe,
  // AXI4-Lite register slave
  input wire logic [`AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int OFF_CYCLES = (`OFF_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int BLANK_CYCLES = (`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int HALF_OSC = (`LOCK_OSC_CYCLES + `LOCK_HALF_DIV - 1) / `LOCK_HALF_DIV;
  localparam int OFF_W = $clog2(OFF_CYCLES);
  localparam int BLANK_W = $clog2(BLANK_CYCLES + 1);
  localparam int STBY_W = $clog2(STBY_CYCLES + 1);
  localparam int LOCK_W = $clog2(`LOCK_OSC_CYCLES + 1);

  function automatic logic hall_valid(input logic [2:0] h);
    return (h != `HALL_ALL_LOW) && (h != `HALL_ALL_HIGH);
  endfunction

  // Returns {source, sink}, phase A in the top bit
  function automatic logic [5:0] commute(input logic [2:0] h, input logic fwd);
    logic [5:0] t;
    t = 6'h00;
    unique case (h)
      3'b101: t = 6'b100_010;
      3'b100: t = 6'b100_001;
      3'b110: t = 6'b010_001;
      3'b010: t = 6'b010_100;
      3'b011: t = 6'b001_100;
      3'b001: t = 6'b001_010;
      default: t = 6'h00;
    endcase
    return fwd ? t : {t[2:0], t[5:3]};
  endfunction

  function automatic logic [2:0] next_hall(input logic [2:0] h, input logic fwd);
    logic [2:0] n;
    n = `HALL_ALL_LOW;
    unique case (h)
      3'b101: n = fwd ? 3'b100 : 3'b001;
      3'b100: n = fwd ? 3'b110 : 3'b101;
      3'b110: n = fwd ? 3'b010 : 3'b100;
      3'b010: n = fwd ? 3'b011 : 3'b110;
      3'b011: n = fwd ? 3'b001 : 3'b010;
      3'b001: n = fwd ? 3'b101 : 3'b011;
      default: n = `HALL_ALL_LOW;
    endcase
    return n;
  endfunction

  function automatic logic addr_ok(input logic [`AXI_ADDR_W-1:0] a);
    return a == `ADDR_CONFIG || a == `ADDR_STATUS || a == `ADDR_GATES;
  endfunction

  pins_type pin_raw;
  pins_type pin_m_r;
  pins_type pin_s_r;
  logic [2:0] hall_q_r;
  logic dir_q_r;
  logic chop_q_r;
  logic osc_q_r;
  chop_state_type ch_state_r;
  logic [OFF_W-1:0] off_cnt_r;
  logic [BLANK_W-1:0] blank_cnt_r;
  logic [STBY_W-1:0] stby_cnt_r;
  logic [LOCK_W-1:0] lock_cnt_r;
  logic [LOCK_W-1:0] half_cnt_r;
  logic lock_fault_r;
  logic fg1_r;
  logic fg2_r;
  logic [1:0] cfg_r;
  gate_type gate_nxt;
  gate_type gate_r;
  status_type status;
  logic aw_hold_r;
  logic w_hold_r;
  logic [`AXI_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic wstrb0_r;
  logic wr_fire;

  // Every pin crosses two flip-flops before use
  assign pin_raw = {phase_a_hall_input, phase_b_hall_input, phase_c_hall_input, direction,
                    chop_input_low_active, brake_request_low, trip_current_reached,
                    pump_voltage_fault, motor_supply_undervoltage, overtemperature,
                    supply_overvoltage_level_exceeded, lock_timer_capacitor_osc,
                    lock_timer_capacitor_grounded, hall_edge_toggle_in, phase_a_toggle_in};

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_m_r <= '0;
      pin_s_r <= '0;
      pin_m_r.brake_n <= `BRAKE_N_RST;
      pin_s_r.brake_n <= `BRAKE_N_RST;
    end else begin
      pin_m_r <= pin_raw;
      pin_s_r <= pin_m_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hall_q_r <= `HALL_ALL_LOW;
      dir_q_r <= 1'b0;
      chop_q_r <= 1'b0;
      osc_q_r <= 1'b0;
    end else begin
      hall_q_r <= pin_s_r.hall;
      dir_q_r <= pin_s_r.dir;
      chop_q_r <= pin_s_r.chop;
      osc_q_r <= pin_s_r.lock_osc;
    end
  end

  logic chop_high;
  logic brake;
  logic hw_fault;
  logic dir_edge;
  logic chop_on_edge;
  logic hall_edge;
  logic osc_rise;
  logic off_done;
  logic trip_ok;
  logic enb_long;
  assign chop_high = pin_s_r.chop;
  assign brake = !pin_s_r.brake_n;
  assign hw_fault = pin_s_r.pump_fault | pin_s_r.supply_uv | pin_s_r.overtemp;
  assign dir_edge = pin_s_r.dir != dir_q_r;
  assign chop_on_edge = chop_q_r && !chop_high;
  assign hall_edge = pin_s_r.hall != hall_q_r;
  assign osc_rise = pin_s_r.lock_osc && !osc_q_r;
  assign off_done = ch_state_r == CH_OFF && off_cnt_r == '0;
  assign trip_ok = ch_state_r == CH_DRIVE && pin_s_r.trip && blank_cnt_r == '0 &&
                   !chop_high && !brake;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ch_state_r <= CH_DRIVE;
      off_cnt_r <= '0;
    end else begin
      unique case (ch_state_r)
        CH_DRIVE: begin
          if (trip_ok) begin
            ch_state_r <= CH_OFF;
            off_cnt_r <= OFF_W'(OFF_CYCLES - 1);
          end
        end
        CH_OFF: begin
          if (off_cnt_r == '0) begin
            ch_state_r <= CH_DRIVE;
          end else begin
            off_cnt_r <= off_cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      blank_cnt_r <= '0;
    end else if (off_done || chop_on_edge || dir_edge) begin
      blank_cnt_r <= BLANK_W'(BLANK_CYCLES);
    end else if (blank_cnt_r != '0) begin
      blank_cnt_r <= blank_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn || !chop_high) begin
      stby_cnt_r <= '0;
    end else if (!enb_long) begin
      stby_cnt_r <= stby_cnt_r + 1'b1;
    end
  end
  assign enb_long = stby_cnt_r == STBY_W'(STBY_CYCLES);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hall_bias_supply <= `HALL_BIAS_RST;
    end else begin
      hall_bias_supply <= !(enb_long && !brake);
    end
  end

  // good step follows the table order
  logic good_step;
  logic lock_hit;
  logic half_clear;
  logic [2:0] hall_p_r;
  // state before the present one; rocking back to it is no step
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      hall_p_r <= `HALL_ALL_LOW;
    end else if (hall_edge) begin
      hall_p_r <= hall_q_r;
    end
  end
  assign good_step = hall_edge && pin_s_r.hall == next_hall(hall_q_r, pin_s_r.dir) &&
                     pin_s_r.hall != hall_p_r;
  assign lock_hit = lock_cnt_r == LOCK_W'(`LOCK_OSC_CYCLES);
  assign half_clear = half_cnt_r == LOCK_W'(HALF_OSC);

  // halted in brake, cleared if grounded
  always_ff @(posedge core_clk) begin
    if (!rstn || lock_fault_r || good_step || dir_edge || pin_s_r.cap_gnd ||
        !cfg_r[`CFG_LOCK_BIT]) begin
      lock_cnt_r <= '0;
    end else if (osc_rise && !brake && !chop_high && !lock_hit) begin
      lock_cnt_r <= lock_cnt_r + 1'b1;
    end
  end

  // half lock time of chop high
  always_ff @(posedge core_clk) begin
    if (!rstn || !chop_high) begin
      half_cnt_r <= '0;
    end else if (osc_rise && !half_clear) begin
      half_cnt_r <= half_cnt_r + 1'b1;
    end
  end

  // latch wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lock_fault_r <= 1'b0;
    end else if (lock_hit) begin
      lock_fault_r <= 1'b1;
    end else if (dir_edge || half_clear) begin
      lock_fault_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fg1_r <= 1'b0;
      fg2_r <= 1'b0;
    end else begin
      fg1_r <= fg1_r ^ hall_edge;
      fg2_r <= fg2_r ^ (pin_s_r.hall[`HALL_A_BIT] != hall_q_r[`HALL_A_BIT]);
    end
  end
  // Open drain pulls low while the toggle state is low
  assign hall_edge_toggle_out = 1'b0;
  assign hall_edge_toggle_oe = !fg1_r;
  assign phase_a_toggle_out = 1'b0;
  assign phase_a_toggle_oe = !fg2_r;

  logic [5:0] cmd;
  logic sr_ok;
  assign cmd = commute(pin_s_r.hall, pin_s_r.dir);
  assign sr_ok = cfg_r[`CFG_SR_BIT] && !pin_s_r.supply_ov;

  always_comb begin
    gate_nxt = '0;
    if (hw_fault) begin
      gate_nxt = '0;
    end else if (brake) begin
      gate_nxt.low = '1;
    end else if (lock_fault_r || enb_long || !hall_valid(pin_s_r.hall)) begin
      gate_nxt = '0;
    end else if (!chop_high && ch_state_r == CH_DRIVE) begin
      gate_nxt.high = cmd[5:3];
      gate_nxt.low = cmd[2:0];
    end else begin
      gate_nxt.high = '0;
      gate_nxt.low = cmd[2:0] | (sr_ok ? cmd[5:3] : 3'b000);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gate_r <= '0;
    end else begin
      gate_r <= gate_nxt;
    end
  end
  assign gate_drive = gate_r;

  assign status = '{fg1: pin_s_r.fg1, fg2: pin_s_r.fg2, brake: brake,
                    supply_ov: pin_s_r.supply_ov, overtemp: pin_s_r.overtemp,
                    supply_uv: pin_s_r.supply_uv, pump_fault: pin_s_r.pump_fault,
                    blanking: blank_cnt_r != '0, chopping: ch_state_r == CH_OFF,
                    lock_fault: lock_fault_r, standby: !hall_bias_supply,
                    dir: pin_s_r.dir, hall: pin_s_r.hall};

  // Write path takes address and data in either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(awaddr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Only the configuration word is writable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg_r <= `CONFIG_RST;
    end else if (wr_fire && awaddr_r == `ADDR_CONFIG && wstrb0_r) begin
      cfg_r <= wdata_r[1:0];
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (s_axi_araddr)
        `ADDR_CONFIG: s_axi_rdata <= 32'(cfg_r);
        `ADDR_STATUS: s_axi_rdata <= 32'(status);
        `ADDR_GATES: s_axi_rdata <= 32'(gate_r);
        default: s_axi_rdata <= '0;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_off_entry;
    ch_state_r == CH_DRIVE ##1 ch_state_r == CH_OFF;
  endsequence
  sequence s_off_exit;
    off_done ##1 ch_state_r == CH_DRIVE;
  endsequence

  property p_trip_off;
    trip_ok |=> ch_state_r == CH_OFF && gate_nxt.high == '0;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip did not start off-time");

  property p_off_len;
    s_off_entry |-> off_cnt_r == OFF_W'(OFF_CYCLES - 1);
  endproperty
  a_off_len: assert property (p_off_len) else $error("off-time load wrong");

  property p_blank_start;
    s_off_exit |-> blank_cnt_r == BLANK_W'(BLANK_CYCLES);
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("blanking not started");

  property p_brake;
    brake && !hw_fault |=> gate_r.low == 3'b111 && gate_r.high == 3'b000;
  endproperty
  a_brake: assert property (p_brake) else $error("brake gates wrong");

  property p_hw_off;
    hw_fault |=> gate_r == '0;
  endproperty
  a_hw_off: assert property (p_hw_off) else $error("gates on under fault");

  property p_ov_no_sr;
    pin_s_r.supply_ov && !brake && chop_high |=> $countones(gate_r.low) <= 1;
  endproperty
  a_ov_no_sr: assert property (p_ov_no_sr) else $error("rectifying under overvoltage");

  property p_fg1;
    hall_edge |=> fg1_r != $past(fg1_r);
  endproperty
  a_fg1: assert property (p_fg1) else $error("first tach missed edge");

  property p_fg2;
    pin_s_r.hall[`HALL_A_BIT] != hall_q_r[`HALL_A_BIT] |=> fg2_r != $past(fg2_r);
  endproperty
  a_fg2: assert property (p_fg2) else $error("second tach missed edge");

  property p_standby;
    enb_long && !brake |=> !hall_bias_supply;
  endproperty
  a_standby: assert property (p_standby) else $error("standby bias still on");

  property p_lock_latch;
    lock_hit |=> lock_fault_r ##1 gate_r == '0 || brake || $past(brake);
  endproperty
  a_lock_latch: assert property (p_lock_latch) else $error("lock fault not latched");

  property p_bad_hall;
    !hall_valid(pin_s_r.hall) && !brake |=> gate_r == '0;
  endproperty
  a_bad_hall: assert property (p_bad_hall) else $error("gates on with bad Hall state");
endmodule
`default_nettype wire

/* bldc_defs.svh */
// Timing, register map and reset constants of the pre-driver control
`ifndef BLDC_DEFS_SVH
`define BLDC_DEFS_SVH
`define CLK_PERIOD_NS 20
`define OFF_TIME_NS 25000
`define BLANK_TIME_NS 1500
`define STBY_TIME_NS 3000000
`define LOCK_OSC_CYCLES 127
`define LOCK_HALF_DIV 2
`define HALL_ALL_LOW 3'h0
`define HALL_ALL_HIGH 3'h7
`define HALL_A_BIT 2
`define BRAKE_N_RST 1'b1
`define HALL_BIAS_RST 1'b1
`define AXI_ADDR_W 4
`define ADDR_CONFIG 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_GATES 4'h8
`define CFG_SR_BIT 0
`define CFG_LOCK_BIT 1
`define CONFIG_RST 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* bldc_pkg.sv */
// Types shared by the pre-driver control
package bldc_pkg;
  typedef struct packed {
    logic [2:0] hall;
    logic dir;
    logic chop;
    logic brake_n;
    logic trip;
    logic pump_fault;
    logic supply_uv;
    logic overtemp;
    logic supply_ov;
    logic lock_osc;
    logic cap_gnd;
    logic fg1;
    logic fg2;
  } pins_type;
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } gate_type;
  typedef struct packed {
    logic fg1;
    logic fg2;
    logic brake;
    logic supply_ov;
    logic overtemp;
    logic supply_uv;
    logic pump_fault;
    logic blanking;
    logic chopping;
    logic lock_fault;
    logic standby;
    logic dir;
    logic [2:0] hall;
  } status_type;
  typedef enum logic {CH_DRIVE, CH_OFF} chop_state_type;
endpackage

/* bldc_far_side.sv */
// Far-side model: lock oscillator and tachometer pull-ups
`timescale 1ns/10ps
`default_nettype none
module bldc_far_side (
  // Clock and control
  input wire logic core_clk,
  input wire logic osc_run,
  // Lock oscillator pin
  output logic lock_osc,
  // Open-drain tachometer pins
  input wire logic fg1_oe,
  input wire logic fg2_oe,
  output logic fg1_pin,
  output logic fg2_pin
);
  logic [1:0] div_r;
  always_ff @(posedge core_clk) begin
    if (!osc_run) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  // Parked low when stopped, so no stray edges
  assign lock_osc = div_r[1];
  assign fg1_pin = fg1_oe ? 1'b0 : 1'b1;
  assign fg2_pin = fg2_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* bldc_predriver_control_test.sv */
// Self-checking bench of the pre-driver control
`timescale 1ns/10ps
`default_nettype none
`include "bldc_defs.svh"
module bldc_predriver_control_test;
  import bldc_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] hall = 3'h5;
  logic dir = 1'b1, chop = 1'b0, brake_n = 1'b1, trip = 1'b0, pump = 1'b0, uv = 1'b0;
  logic ov = 1'b0, hot = 1'b0, cap_gnd = 1'b1, osc_run = 1'b0;
  logic lock_osc, fg1_pin, fg2_pin, fg1_oe, fg2_oe, bias;
  gate_type gates;
  logic [`AXI_ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int error_cnt = 0;
  int n_checks = 0;

  // Short standby count keeps the run brief
  bldc_predriver_control #(.STBY_CYCLES(50)) i_dut (
    .core_clk(core_clk), .rstn(rstn),
    .phase_a_hall_input(hall[2]), .phase_b_hall_input(hall[1]), .phase_c_hall_input(hall[0]),
    .direction(dir), .chop_input_low_active(chop), .brake_request_low(brake_n),
    .trip_current_reached(trip), .pump_voltage_fault(pump), .motor_supply_undervoltage(uv),
    .supply_overvoltage_level_exceeded(ov), .overtemperature(hot),
    .lock_timer_capacitor_osc(lock_osc), .lock_timer_capacitor_grounded(cap_gnd),
    .gate_drive(gates), .hall_bias_supply(bias),
    .hall_edge_toggle_in(fg1_pin), .hall_edge_toggle_out(), .hall_edge_toggle_oe(fg1_oe),
    .phase_a_toggle_in(fg2_pin), .phase_a_toggle_out(), .phase_a_toggle_oe(fg2_oe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  bldc_far_side i_far (
    .core_clk(core_clk), .osc_run(osc_run), .lock_osc(lock_osc),
    .fg1_oe(fg1_oe), .fg2_oe(fg2_oe), .fg1_pin(fg1_pin), .fg2_pin(fg2_pin)
  );

  always #10 core_clk = ~core_clk;

  function automatic gate_type drv(input logic d, input logic [2:0] h);
    gate_type g;
    case (h)
      3'h5: g = '{3'h4, 3'h2};
      3'h4: g = '{3'h4, 3'h1};
      3'h6: g = '{3'h2, 3'h1};
      3'h2: g = '{3'h2, 3'h4};
      3'h3: g = '{3'h1, 3'h4};
      3'h1: g = '{3'h1, 3'h2};
      default: g = '{3'h0, 3'h0};
    endcase
    if (!d) g = '{g.low, g.high};
    return g;
  endfunction
  function automatic gate_type offp(input gate_type g, input logic sr);
    return '{3'h0, sr ? (g.low | g.high) : g.low};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Gates are looked at mid-cycle, away from the launching edge
  task automatic gchk(input int n, input gate_type e);
    step(n);
    @(negedge core_clk);
    chk_w("gates", 32'(e), 32'(gates));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      if (!aw_p && !w_p && bvalid) begin
        r = bresp;
        break;
      end
      if (awready) aw_p = 1'b0;
      if (wready) w_p = 1'b0;
      step(1);
      if (!aw_p) awvalid <= 1'b0;
      if (!w_p) wvalid <= 1'b0;
    end
    step(1);
    if (n == 40) begin
      error_cnt++;
      $display("Error write response expected in 40 cycles seen none");
      tally_and_finish();
    end
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_p;
    ar_p = 1'b1;
    d = 32'hffffffff;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge core_clk);
      if (!ar_p && rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
      if (arready) ar_p = 1'b0;
      step(1);
      if (!ar_p) arvalid <= 1'b0;
    end
    step(1);
    if (n == 40) begin
      error_cnt++;
      $display("Error read data expected in 40 cycles seen none");
      tally_and_finish();
    end
  endtask

  task automatic test_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(`ADDR_CONFIG, d, r);
    chk_w("config", 32'(`CONFIG_RST), d);
    axi_rd(4'hc, d, r);
    chk_w("unmapped rdata", 32'h0, d);
    chk_w("unmapped rresp", 32'(`RESP_SLVERR), 32'(r));
    axi_wr(4'hc, 32'h0, r);
    chk_w("unmapped bresp", 32'(`RESP_SLVERR), 32'(r));
    axi_rd(`ADDR_GATES, d, r);
    chk_w("gates reg", 32'(drv(1'b1, 3'h5)), d);
    $display("test_regs done");
  endtask
  task automatic test_table();
    logic [2:0] seq [16] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5, 3'h4,
                             3'h6, 3'h2, 3'h3, 3'h1, 3'h0, 3'h1, 3'h3, 3'h7};
    logic [2:0] h;
    logic [31:0] d;
    logic [1:0] r;
    logic e1, e2;
    @(negedge core_clk);
    e1 = fg1_oe;
    e2 = fg2_oe;
    for (int k = 0; k < 17; k++) begin
      h = (k < 16) ? seq[k] : 3'h5;
      step(1);
      if (k == 6) dir <= 1'b0;
      e1 = e1 ^ (h != hall);
      e2 = e2 ^ (h[2] != hall[2]);
      hall <= h;
      gchk(5, drv(k < 6, h));
      chk_w("fg1 oe", 32'(e1), 32'(fg1_oe));
      chk_w("fg2 oe", 32'(e2), 32'(fg2_oe));
    end
    step(1);
    axi_rd(`ADDR_STATUS, d, r);
    chk_w("status", {17'h0, ~e1, ~e2, 9'h0, 1'b0, 3'h5}, d & 32'h600f);
    dir <= 1'b1;
    $display("test_table done");
  endtask
  task automatic test_chop();
    logic [1:0] r;
    step(10);
    chop <= 1'b1;
    gchk(5, offp(drv(1'b1, 3'h5), 1'b1));
    step(1);
    ov <= 1'b1;
    gchk(5, offp(drv(1'b1, 3'h5), 1'b0));
    step(1);
    ov <= 1'b0;
    chop <= 1'b0;
    axi_wr(`ADDR_CONFIG, 32'h2, r);
    chop <= 1'b1;
    gchk(5, offp(drv(1'b1, 3'h5), 1'b0));
    step(1);
    chop <= 1'b0;
    axi_wr(`ADDR_CONFIG, 32'h3, r);
    gchk(5, drv(1'b1, 3'h5));
    $display("test_chop done");
  endtask
  task automatic test_brake();
    step(1);
    brake_n <= 1'b0;
    chop <= 1'b1;
    gchk(5, '{3'h0, 3'h7});
    step(1);
    chop <= 1'b0;
    gchk(5, '{3'h0, 3'h7});
    step(1);
    brake_n <= 1'b1;
    gchk(5, drv(1'b1, 3'h5));
    $display("test_brake done");
  endtask
  task automatic test_trip();
    step(100);
    trip <= 1'b1;
    step(1);
    trip <= 1'b0;
    gchk(10, offp(drv(1'b1, 3'h5), 1'b1));
    gchk(1190, offp(drv(1'b1, 3'h5), 1'b1));
    gchk(60, drv(1'b1, 3'h5));
    // Trip inside the blanking window must not cut the source
    step(1);
    trip <= 1'b1;
    step(1);
    trip <= 1'b0;
    gchk(10, drv(1'b1, 3'h5));
    step(100);
    chop <= 1'b1;
    step(10);
    chop <= 1'b0;
    step(1);
    trip <= 1'b1;
    step(1);
    trip <= 1'b0;
    gchk(10, drv(1'b1, 3'h5));
    $display("test_trip done");
  endtask
  task automatic test_standby();
    step(100);
    chop <= 1'b1;
    gchk(70, '{3'h0, 3'h0});
    chk_w("bias", 32'h0, 32'(bias));
    step(1);
    chop <= 1'b0;
    gchk(10, drv(1'b1, 3'h5));
    chk_w("bias", 32'h1, 32'(bias));
    step(1);
    // brake kept low, so standby must stay out
    brake_n <= 1'b0;
    chop <= 1'b1;
    gchk(70, '{3'h0, 3'h7});
    chk_w("bias", 32'h1, 32'(bias));
    step(1);
    brake_n <= 1'b1;
    chop <= 1'b0;
    gchk(10, drv(1'b1, 3'h5));
    $display("test_standby done");
  endtask
  task automatic test_faults();
    for (int k = 0; k < 4; k++) begin
      step(1);
      pump <= (k == 0);
      uv <= (k == 1);
      hot <= (k == 2);
      rstn <= (k != 3);
      gchk(5, '{3'h0, 3'h0});
      step(1);
      pump <= 1'b0;
      uv <= 1'b0;
      hot <= 1'b0;
      rstn <= 1'b1;
      gchk(8, drv(1'b1, 3'h5));
    end
    $display("test_faults done");
  endtask
  task automatic test_lock();
    step(1);
    osc_run <= 1'b1;
    gchk(600, drv(1'b1, 3'h5));
    step(1);
    cap_gnd <= 1'b0;
    step(300);
    brake_n <= 1'b0;
    step(300);
    brake_n <= 1'b1;
    gchk(150, drv(1'b1, 3'h5));
    gchk(150, '{3'h0, 3'h0});
    step(1);
    dir <= 1'b0;
    gchk(10, drv(1'b0, 3'h5));
    gchk(600, '{3'h0, 3'h0});
    step(1);
    chop <= 1'b1;
    step(300);
    chop <= 1'b0;
    gchk(10, drv(1'b0, 3'h5));
    // Rocking between two states is a lock too
    for (int k = 0; k < 160; k++) begin
      step(4);
      hall <= k[0] ? 3'h5 : 3'h1;
    end
    gchk(10, '{3'h0, 3'h0});
    step(1);
    osc_run <= 1'b0;
    cap_gnd <= 1'b1;
    dir <= 1'b1;
    $display("test_lock done");
  endtask

  initial begin
    step(2);
    rstn <= 1'b1;
    step(3);
    test_regs();
    test_table();
    test_chop();
    test_brake();
    test_trip();
    test_standby();
    test_faults();
    test_lock();
    tally_and_finish();
  end
endmodule
`default_nettype wire
